//--- hw/rwt_consts.vh
// constants for the register window translator
// assumes a 16-bit core address space and byte-wide registers
`ifndef RWT_CONSTS_VH
`define RWT_CONSTS_VH
`define RWT_OFF_SEL0 8'h00
`define RWT_OFF_SEL1 8'h04
`define RWT_OFF_CTRL 8'h08
`define RWT_OFF_STAT 8'h0c
`define RWT_OFF_CORE_SEL 8'h14
`define RWT_SEL_RST 8'h00
`define RWT_CTRL_RST 8'h00
`define RWT_CTRL_NOWIN_BIT 0
`define RWT_BASE_P32 16'h00e0
`define RWT_BASE_S32 16'h0060
`define RWT_BASE_P64 16'h00c0
`define RWT_BASE_S64 16'h0040
`define RWT_BASE_P128 16'h0080
`define RWT_LOWER_TOP 16'h00ff
`define RWT_BLOCK_LO 16'h1fe0
`define RWT_BLOCK_HI 16'h1fff
`define RWT_BLOCK_READ 8'hff
`define RWT_CODE_128_LO 8'h10
`define RWT_CODE_64_LO 8'h20
`define RWT_CODE_32_LO 8'h40
`define RWT_SIZE_NONE 2'd0
`define RWT_SIZE_32 2'd1
`define RWT_SIZE_64 2'd2
`define RWT_SIZE_128 2'd3
`endif

//--- hw/rwt_decode.v
// selector decoder: window size and upper-area base from one selector
// assumes selector is a registered value on the same clock
`timescale 1ns/100ps
`include "rwt_consts.vh"
module rwt_decode #(
    parameter [15:0] BASE32 = 16'h00e0,
    parameter [15:0] BASE64 = 16'h00c0,
    parameter ALLOW128 = 1
) (
    input wire [7:0] sel_i,
    output reg [1:0] size_o,
    output reg [15:0] lower_base_o,
    output reg [15:0] upper_base_o
);
    reg [10:0] raw;

    always @* begin
        size_o = `RWT_SIZE_NONE;
        lower_base_o = 16'h0000;
        raw = 11'h000;
        // codes 40-7f: 32-byte, 20-3f: 64-byte, 10-1f: 128-byte
        if (sel_i[6:0] >= `RWT_CODE_32_LO) begin
            size_o = `RWT_SIZE_32;
            lower_base_o = BASE32;
            raw = {sel_i[5:0], 5'h00};
        end else if (sel_i[6:0] >= `RWT_CODE_64_LO) begin
            size_o = `RWT_SIZE_64;
            lower_base_o = BASE64;
            raw = {sel_i[4:0], 6'h00};
        end else if ((sel_i[6:0] >= `RWT_CODE_128_LO) &&
                (ALLOW128 != 0)) begin
            size_o = `RWT_SIZE_128;
            lower_base_o = `RWT_BASE_P128;
            raw = {sel_i[3:0], 7'h00};
        end
        // indices past the upper file land in the sfr block 1c00-1fff
        upper_base_o = {3'b000, raw[10], raw[10], raw[10:0]};
    end
endmodule // rwt_decode

//--- hw/rwt_top.v
// register window translator: maps direct core addresses through windows
// assumes a classic wishbone master and a core issuing one access a cycle
// Operation
// - target is upper base plus (direct address minus lower window base)
// - primary 32-byte window covers direct addresses from 00e0
// - secondary 32-byte window covers direct addresses from 0060
// - primary 64-byte window covers direct addresses from 00c0
// - secondary 64-byte window covers direct addresses from 0040
// - 128-byte window exists only on primary selector, from 0080
// - windowed reads of 1fe0-1fff return ff when sfrs are mapped
// - windowed writes to 1fe0-1fff are dropped when sfrs are mapped
// - 1f80-1fdf still translate normally in a 128-byte window
// - primary selector low seven bits zero disables all windowing
// - indirect and indexed accesses go to the actual address
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/100ps
`include "rwt_consts.vh"
module rwt_top (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire core_req_i,
    input wire core_we_i,
    input wire core_direct_i,
    input wire [15:0] core_adr_i,
    input wire [7:0] core_wdata_i,
    input wire [7:0] mem_rdata_i,
    output reg mem_req_o,
    output reg mem_we_o,
    output reg [15:0] mem_adr_o,
    output reg [7:0] mem_wdata_o,
    output reg [7:0] core_rdata_o,
    output reg core_rvalid_o
);
    reg [7:0] sel0;
    reg [7:0] sel1;
    reg [7:0] ctrl;
    reg [7:0] hits;
    reg use_sec;
    reg in_win;
    reg blocked;
    reg [15:0] target;
    reg [15:0] offs;
    reg pend_rd;
    reg pend_blk;
    reg [31:0] next_rdata;
    reg next_mem_req;
    reg next_mem_we;
    reg next_pend_rd;
    reg [7:0] next_core_rdata;
    reg [7:0] next_sel0;
    reg [7:0] next_sel1;
    reg [7:0] next_ctrl;
    reg [7:0] next_hits;
    wire wb_wr;
    wire [1:0] p_size;
    wire [15:0] p_lbase;
    wire [15:0] p_ubase;
    wire [1:0] s_size;
    wire [15:0] s_lbase;
    wire [15:0] s_ubase;
    wire [1:0] size;
    wire [15:0] lbase;
    wire [15:0] ubase;
    wire win_off;
    wire core_sel_wr;
    wire wb_go;

    // primary selector
    rwt_decode #(
        .BASE32(`RWT_BASE_P32),
        .BASE64(`RWT_BASE_P64),
        .ALLOW128(1)
    ) u_dec_pri (
        .sel_i(sel0),
        .size_o(p_size),
        .lower_base_o(p_lbase),
        .upper_base_o(p_ubase)
    );

    // secondary selector, no 128-byte codes
    rwt_decode #(
        .BASE32(`RWT_BASE_S32),
        .BASE64(`RWT_BASE_S64),
        .ALLOW128(0)
    ) u_dec_sec (
        .sel_i(sel1),
        .size_o(s_size),
        .lower_base_o(s_lbase),
        .upper_base_o(s_ubase)
    );

    assign win_off = (sel0[6:0] == 7'h00);
    assign core_sel_wr = core_req_i && core_direct_i && core_we_i &&
        (core_adr_i == {8'h00, `RWT_OFF_CORE_SEL});
    assign wb_go = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // pick which window, if any, covers the direct address
    always @* begin
        use_sec = 1'b0;
        in_win = 1'b0;
        if (!win_off && (p_size != `RWT_SIZE_NONE) &&
                core_adr_i >= p_lbase &&
                core_adr_i <= `RWT_LOWER_TOP) begin
            in_win = 1'b1;
        end else if (!win_off && (s_size != `RWT_SIZE_NONE) &&
                core_adr_i >= s_lbase &&
                core_adr_i < s_lbase + ((s_size == `RWT_SIZE_32) ?
                16'h0020 : 16'h0040)) begin
            in_win = 1'b1;
            use_sec = 1'b1;
        end
        // indirect and indexed bypass every window
        if (!core_direct_i) begin
            in_win = 1'b0;
        end
    end

    assign size = use_sec ? s_size : p_size;
    assign lbase = use_sec ? s_lbase : p_lbase;
    assign ubase = use_sec ? s_ubase : p_ubase;

    // offset within window, added to the aligned upper area
    always @* begin
        offs = core_adr_i - lbase;
        target = core_adr_i;
        if (in_win) begin
            target = ubase + offs;
        end
        // only the top 32 sfr locations are unwindowable
        blocked = in_win && !ctrl[`RWT_CTRL_NOWIN_BIT] &&
            target >= `RWT_BLOCK_LO && target <= `RWT_BLOCK_HI;
    end

    assign wb_wr = wb_go && wb_we_i && wb_sel_i[0];

    // memory request; blocked writes never reach memory
    always @* begin
        next_mem_req = 1'b0;
        next_mem_we = 1'b0;
        if (core_req_i) begin
            next_mem_req = !(blocked && core_we_i);
            next_mem_we = core_we_i && !blocked;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
        end else begin
            mem_req_o <= next_mem_req;
            mem_we_o <= next_mem_we;
        end
    end

    // translated address and write data follow every cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            mem_adr_o <= 16'h0000;
            mem_wdata_o <= 8'h00;
        end else begin
            mem_adr_o <= target;
            mem_wdata_o <= core_wdata_i;
        end
    end

    // read bookkeeping for the answer one cycle later
    always @* begin
        next_pend_rd = core_req_i && !core_we_i;
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            pend_rd <= 1'b0;
            pend_blk <= 1'b0;
        end else begin
            pend_rd <= next_pend_rd;
            pend_blk <= blocked;
        end
    end

    // memory data is taken in the cycle the request stands
    always @* begin
        next_core_rdata = core_rdata_o;
        if (pend_rd) begin
            if (pend_blk) begin
                next_core_rdata = `RWT_BLOCK_READ;
            end else begin
                next_core_rdata = mem_rdata_i;
            end
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            core_rdata_o <= 8'h00;
            core_rvalid_o <= 1'b0;
        end else begin
            core_rdata_o <= next_core_rdata;
            core_rvalid_o <= pend_rd;
        end
    end

    // primary selector: a direct core write wins over wishbone
    always @* begin
        next_sel0 = sel0;
        if (core_sel_wr) begin
            next_sel0 = core_wdata_i;
        end else if (wb_wr && wb_adr_i == `RWT_OFF_SEL0) begin
            next_sel0 = wb_dat_i[7:0];
        end
    end

    // secondary selector and control
    always @* begin
        next_sel1 = sel1;
        next_ctrl = ctrl;
        if (wb_wr && wb_adr_i == `RWT_OFF_SEL1) begin
            next_sel1 = wb_dat_i[7:0];
        end
        if (wb_wr && wb_adr_i == `RWT_OFF_CTRL) begin
            next_ctrl = {7'h00, wb_dat_i[`RWT_CTRL_NOWIN_BIT]};
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            sel0 <= `RWT_SEL_RST;
            sel1 <= `RWT_SEL_RST;
            ctrl <= `RWT_CTRL_RST;
        end else begin
            sel0 <= next_sel0;
            sel1 <= next_sel1;
            ctrl <= next_ctrl;
        end
    end

    // count of direct accesses that went through a window
    always @* begin
        next_hits = hits;
        if (core_req_i && in_win) begin
            next_hits = hits + 8'h01;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            hits <= 8'h00;
        end else begin
            hits <= next_hits;
        end
    end

    // one-cycle acknowledge; read data captured with it
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_go;
            if (wb_go) begin
                wb_dat_o <= next_rdata;
            end
        end
    end

    // register read mux; unmapped offsets read zero

    always @* begin
        next_rdata = 32'h00000000;
        case (wb_adr_i)
            `RWT_OFF_SEL0: next_rdata = {24'h000000, sel0};
            `RWT_OFF_SEL1: next_rdata = {24'h000000, sel1};
            `RWT_OFF_CTRL: next_rdata = {24'h000000, ctrl};
            `RWT_OFF_STAT: next_rdata = {16'h0000, hits, 4'h0,
                win_off, 1'b0, s_size};
            default: next_rdata = 32'h00000000;
        endcase
    end
endmodule // rwt_top

//--- bench/rwt_mem_model.sv
// byte memory standing behind the translator's memory port
// assumes read data is taken in the cycle that mem_req_o stands
`timescale 1ns/100ps
module rwt_mem_model (
    input logic clk_i,
    input logic mem_req_o,
    input logic mem_we_o,
    input logic [15:0] mem_adr_o,
    input logic [7:0] mem_wdata_o,
    output logic [7:0] mem_rdata_i
);
    logic [7:0] m [0:65535];
    initial begin
        for (int i = 0; i < 65536; i++) m[i] = i[7:0] ^ i[15:8];
    end
    // idle data is inverted so a stale value never looks valid
    always_comb mem_rdata_i = mem_req_o ? m[mem_adr_o] : ~m[mem_adr_o];
    always @(posedge clk_i) begin
        if (mem_req_o && mem_we_o) m[mem_adr_o] <= mem_wdata_o;
    end
endmodule // rwt_mem_model

//--- bench/rwt_monitor.sv
// port checker for the register window translator
// assumes a single clock and the wishbone offsets of the design
`timescale 1ns/100ps
module rwt_monitor (
    input logic clk_i,
    input logic rst_i,
    input logic wb_cyc_i,
    input logic wb_stb_i,
    input logic wb_we_i,
    input logic [7:0] wb_adr_i,
    input logic [31:0] wb_dat_i,
    input logic wb_ack_o,
    input logic core_req_i,
    input logic core_we_i,
    input logic core_direct_i,
    input logic [15:0] core_adr_i,
    input logic [7:0] core_wdata_i,
    input logic mem_req_o,
    input logic mem_we_o,
    input logic [15:0] mem_adr_o,
    input logic [7:0] mem_wdata_o,
    input logic [7:0] core_rdata_o,
    input logic core_rvalid_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic nowin;
    logic low;
    assign low = core_req_i && core_direct_i && core_adr_i <= 16'h00ff;
    // shadow of the control bit that unblocks the top range
    always @(posedge clk_i) begin
        if (rst_i) nowin <= 1'b0;
        else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h08)
            nowin <= wb_dat_i[0];
    end
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("ack missing");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_read_valid: assert property (core_req_i && !core_we_i
        |-> ##2 core_rvalid_o) else $error("no read valid");
    a_indirect_pass: assert property (core_req_i && !core_direct_i
        |=> mem_req_o && mem_adr_o == $past(core_adr_i))
        else $error("indirect address altered");
    a_upper_pass: assert property (core_req_i && core_adr_i > 16'h00ff
        |=> mem_adr_o == $past(core_adr_i)) else $error("upper altered");
    a_wdata_pass: assert property (core_req_i && core_we_i
        && !core_direct_i |=> mem_we_o && mem_wdata_o == $past(core_wdata_i))
        else $error("write data lost");
    a_block_read: assert property (low && !core_we_i && !nowin
        ##1 mem_adr_o >= 16'h1fe0 |=> core_rdata_o == 8'hff)
        else $error("blocked read not ff");
    a_block_write: assert property (low && core_we_i && !nowin
        |=> !(mem_we_o && mem_adr_o >= 16'h1fe0))
        else $error("blocked write leaked");
    c_direct_read: cover property (low && !core_we_i);
    c_top_hit: cover property (mem_req_o && mem_adr_o >= 16'h1fe0);
    c_reg_write: cover property (wb_ack_o && wb_we_i);
endmodule // rwt_monitor
bind rwt_top rwt_monitor u_mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o, .core_req_i, .core_we_i,
    .core_direct_i, .core_adr_i, .core_wdata_i, .mem_req_o, .mem_we_o,
    .mem_adr_o, .mem_wdata_o, .core_rdata_o, .core_rvalid_o);

//--- bench/testbench.sv
// self-checking bench: wishbone setup, then direct and indirect accesses
// assumes the memory model answers every translated access
`timescale 1ns/100ps
module testbench;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic core_req_i = 0, core_we_i = 0, core_direct_i = 0;
    logic mem_req_o, mem_we_o, wb_ack_o, core_rvalid_o;
    logic [7:0] wb_adr_i = 0, core_wdata_i = 0;
    logic [7:0] mem_rdata_i, mem_wdata_o, core_rdata_o;
    logic [15:0] core_adr_i = 0, mem_adr_o;
    logic [31:0] wb_dat_i = 0, wb_dat_o, r;
    int bad_count = 0, checks = 0, cyc = 0;
    always #20 clk_i = ~clk_i;
    rwt_top dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i(4'h1), .wb_dat_i, .wb_dat_o, .wb_ack_o, .core_req_i,
        .core_we_i, .core_direct_i, .core_adr_i, .core_wdata_i, .mem_rdata_i,
        .mem_req_o, .mem_we_o, .mem_adr_o, .mem_wdata_o, .core_rdata_o,
        .core_rvalid_o);
    rwt_mem_model mem (.clk_i, .mem_req_o, .mem_we_o, .mem_adr_o,
        .mem_wdata_o, .mem_rdata_i);
    task check(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task report_and_stop;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w; wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        wb_cyc_i <= 0; wb_stb_i <= 0;
    endtask
    // selectors and control, then one core access and its result
    task run(input logic [7:0] p, s, input logic c, w, d,
             input logic [15:0] a, e);
        logic b;
        b = d && !c && a <= 16'h00ff && e >= 16'h1fe0;
        wb(1, 8'h00, {24'h0, p});
        wb(1, 8'h04, {24'h0, s});
        wb(1, 8'h08, {31'h0, c});
        @(posedge clk_i);
        core_req_i <= 1; core_we_i <= w; core_direct_i <= d;
        core_adr_i <= a; core_wdata_i <= a[7:0] ^ 8'ha5;
        @(posedge clk_i);
        core_req_i <= 0;
        #1 check(mem_req_o, !(b && w));
        if (!(b && w)) check(mem_adr_o, e);
        if (w && !b) check(mem_wdata_o, a[7:0] ^ 8'ha5);
        if (!w) begin
            @(posedge clk_i);
            #1 check(core_rvalid_o, 1);
            check(core_rdata_o, b ? 8'hff : e[7:0] ^ e[15:8]);
        end
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            bad_count++;
            report_and_stop;
        end
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 0;
        wb(0, 8'h00, 0); check(r, 0);
        wb(0, 8'h10, 0); check(r, 0);
        run(8'h00, 8'h00, 0, 0, 1, 16'h00e5, 16'h00e5);
        run(8'h80, 8'h4a, 0, 0, 1, 16'h006b, 16'h006b);
        run(8'h4a, 8'h00, 0, 0, 1, 16'h00eb, 16'h014b);
        run(8'h01, 8'h4a, 0, 0, 1, 16'h006b, 16'h014b);
        run(8'h3e, 8'h00, 0, 0, 1, 16'h00cc, 16'h1f8c);
        run(8'h01, 8'h3e, 0, 0, 1, 16'h004c, 16'h1f8c);
        run(8'h1f, 8'h00, 0, 0, 1, 16'h0082, 16'h1f82);
        run(8'h01, 8'h1f, 0, 0, 1, 16'h0082, 16'h0082);
        run(8'h1f, 8'h00, 0, 0, 1, 16'h00e7, 16'h1fe7);
        run(8'h1f, 8'h00, 1, 0, 1, 16'h00e7, 16'h1fe7);
        run(8'h1f, 8'h00, 0, 1, 1, 16'h00e7, 16'h1fe7);
        run(8'h1f, 8'h00, 0, 0, 0, 16'h0082, 16'h0082);
        run(8'h4a, 8'h00, 0, 1, 1, 16'h00eb, 16'h014b);
        run(8'h1f, 8'h00, 0, 1, 0, 16'h1fe7, 16'h1fe7);
        wb(0, 8'h00, 0); check(r, 32'h1f);
        wb(0, 8'h0c, 0); check(r, 32'h0900);
        report_and_stop;
    end
endmodule // testbench
